// >>> dv/int_partner.sv
`timescale 1ns/1ps
// far side: external wake pin and the core's interrupt handshake
module int_partner (
	input wire logic clk,
	output logic intPending,
	output logic extIntN,
	output logic retDone
);
	// pin idles high through its pull-up
	initial
	begin
		intPending = 1'b0;
		extIntN = 1'b1;
		retDone = 1'b0;
	end
	// a hold shorter than the wake count is a deliberately bad pulse
	task automatic holdLow(input int n);
		@(posedge clk);
		extIntN <= 1'b0;
		repeat (n) @(posedge clk);
		extIntN <= 1'b1;
	endtask
	// pending stays up until the core takes it
	task automatic pend(input logic v);
		@(posedge clk);
		intPending <= v;
	endtask
	// core finished its handler
	task automatic ret();
		@(posedge clk);
		retDone <= 1'b1;
		@(posedge clk);
		retDone <= 1'b0;
	endtask
endmodule

// >>> dv/power_saving_mode_control_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
$display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module power_saving_mode_control_tb_top;
	import power_pkg::*;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, lastErr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r, m;
	logic intPending, extIntN, retDone, clkRun, pcHalt, intAck, resumeNext;
	logic addrLatchStrobe, program_store_strobe_n, irq;
	int num_errors, samples_checked;
	power_saving_mode_control power_saving_mode_control_inst (
		.clk(clk),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.intPending(intPending),
		.extIntN(extIntN),
		.retDone(retDone),
		.clkRun(clkRun),
		.pcHalt(pcHalt),
		.intAck(intAck),
		.resumeNext(resumeNext),
		.addrLatchStrobe(addrLatchStrobe),
		.program_store_strobe_n(program_store_strobe_n),
		.irq(irq)
	);
	int_partner int_partner_inst (.clk(clk), .intPending(intPending), .extIntN(extIntN),
		.retDone(retDone));
	// free-running clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic test_done();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// one apb transfer; waits on pready under a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			num_errors++;
			test_done();
		end
		r = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// bounded wait for a one-cycle pulse
	task automatic waitSig(ref logic s);
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (s !== 1'b1 && n < 2000);
		`CHK(s, 1'b1)
	endtask
	function automatic logic [1:0] expMode(input logic [1:0] c);
		return c[PDOWN_BIT] ? 2'h2 : (c[IDLE_BIT] ? 2'h1 : 2'h0);
	endfunction
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		rst = 1'b1;
		num_errors = 0;
		samples_checked = 0;
		void'($urandom(32'hee54));
		#200000 num_errors++;
		test_done();
	end
	// main sequence
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		apb(0, IRQ_STAT_OFS, 0);
		`CHK(r[2:0], 3'h4)
		m = $urandom & 32'h7;
		apb(1, IRQ_MASK_OFS, m);
		apb(0, 8'h14, 0);
		`CHK(irq, m[2])
		`CHK({lastErr, r}, 33'h100000000)
		apb(1, IRQ_STAT_OFS, 32'h4);
		apb(1, IRQ_MASK_OFS, 32'h7);
		`CHK(irq, 1'b0)
		$display("test irq done");
		apb(1, CTRL_OFS, 32'h1);
		repeat (20) @(posedge clk);
		apb(0, STAT_OFS, 0);
		`CHK(r[1:0], expMode(2'h1))
		`CHK({clkRun, pcHalt, addrLatchStrobe, program_store_strobe_n}, 4'hf)
		int_partner_inst.pend(1'b1);
		waitSig(intAck);
		`CHK(irq, 1'b1)
		int_partner_inst.pend(1'b0);
		apb(0, CTRL_OFS, 0);
		`CHK(r[1:0], 2'h0)
		int_partner_inst.ret();
		waitSig(resumeNext);
		apb(1, IRQ_STAT_OFS, 32'h7);
		$display("test idle done");
		apb(1, EXTCFG_OFS, 32'h3);
		apb(1, CTRL_OFS, 32'h2);
		apb(0, IRQ_MASK_OFS, 0);
		`CHK(r[2:0], 3'h7)
		apb(0, STAT_OFS, 0);
		`CHK(r[1:0], expMode(2'h2))
		`CHK({clkRun, pcHalt, addrLatchStrobe, program_store_strobe_n}, 4'h4)
		int_partner_inst.holdLow(16 + $urandom % 900);
		repeat (4) @(posedge clk);
		apb(0, STAT_OFS, 0);
		`CHK(r[1:0], 2'h2)
		int_partner_inst.holdLow(WAKE_LOW_CYCLES + 4);
		waitSig(intAck);
		apb(0, CTRL_OFS, 0);
		`CHK(r[1:0], 2'h0)
		$display("test powerdown done");
		apb(1, EXTCFG_OFS, 32'h1);
		apb(1, CTRL_OFS, 32'h3);
		int_partner_inst.holdLow(1100);
		repeat (4) @(posedge clk);
		apb(0, STAT_OFS, 0);
		`CHK(r[1:0], expMode(2'h3))
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		apb(0, CTRL_OFS, 0);
		`CHK({r[1:0], clkRun, program_store_strobe_n}, 4'h3)
		apb(1, CTRL_OFS, 32'h1);
		apb(0, STAT_OFS, 0);
		`CHK(r[1:0], 2'h1)
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		apb(0, STAT_OFS, 0);
		`CHK({r[1:0], pcHalt}, 3'h0)
		$display("test reset done");
		test_done();
	end
endmodule

// >>> verilog/power_pkg.sv
package power_pkg;
	// power control register layout, all offsets are byte addresses
	localparam logic [7:0] CTRL_OFS = 8'h00; // power_control_register
	localparam logic [7:0] STAT_OFS = 8'h04; // state and wake status, read only
	localparam logic [7:0] IRQ_STAT_OFS = 8'h08; // sticky events, write one to clear
	localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
	localparam logic [7:0] EXTCFG_OFS = 8'h10; // external interrupt enable and level mode
	localparam int IDLE_BIT = 0;
	localparam int PDOWN_BIT = 1;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [2:0] MASK_RESET = 3'h0;
	localparam logic [2:0] STAT_RESET = 3'h4; // reset-wake event is set out of reset
	localparam logic [1:0] EXTCFG_RESET = 2'h0;
	// event bits
	localparam int EV_IDLE_WAKE = 0;
	localparam int EV_PDOWN_WAKE = 1;
	localparam int EV_RESET_WAKE = 2;
	// low time the external wake pin must hold before release
	localparam int WAKE_LOW_CYCLES = 1024;
	localparam int WAKE_CNT_W = 11;
	typedef enum logic [1:0] {RUN, IDLE, PDOWN, WAKE} pmode_t;
endpackage

// >>> verilog/power_saving_mode_control.sv
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
module power_saving_mode_control
	import power_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic intPending,
	input wire logic extIntN,
	input wire logic retDone,
	output logic clkRun,
	output logic pcHalt,
	output logic intAck,
	output logic resumeNext,
	output logic addrLatchStrobe,
	output logic program_store_strobe_n,
	output logic irq
);
	logic extSync;
	pmode_t mode_q, mode_d;
	logic [1:0] pwrReq_q, pwrReq_d;
	logic [1:0] extCfg_q, extCfg_d;
	logic [2:0] evStat_q, evStat_d;
	logic [2:0] evMask_q, evMask_d;
	logic [WAKE_CNT_W-1:0] lowCnt_q, lowCnt_d;
	logic resumePend_q, resumePend_d;
	logic [31:0] prdata_d;
	logic pready_d, pslverr_d, intAck_d, resumeNext_d, irq_d;
	logic clkRun_d, pcHalt_d, ale_d, pss_d;
	logic wr, rd;
	logic [2:0] evSet;

	sync2 extPinSync (
		.clk(clk),
		.rst(rst),
		.d(extIntN),
		.q(extSync)
	);

	// zero-wait apb slave; reads decode in setup so data stands beside pready
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;

	// mode controller, request bits and wake timing
	always_comb
	begin
		mode_d = mode_q;
		pwrReq_d = pwrReq_q;
		lowCnt_d = lowCnt_q;
		intAck_d = 1'b0;
		resumePend_d = resumePend_q;
		resumeNext_d = 1'b0;
		evSet = 3'h0;
		if (wr && paddr == CTRL_OFS)
		begin
			pwrReq_d = pwdata[1:0];
		end
		case (mode_q)
			RUN:
			begin
				if (pwrReq_d[PDOWN_BIT])
				begin
					mode_d = PDOWN;
				end
				else if (pwrReq_d[IDLE_BIT])
				begin
					mode_d = IDLE;
				end
				if (resumePend_q && retDone)
				begin
					resumeNext_d = 1'b1;
					resumePend_d = 1'b0;
				end
			end
			IDLE:
			begin
				// only an enabled interrupt leaves idle; bus writes cannot
				if (intPending)
				begin
					pwrReq_d[IDLE_BIT] = 1'b0;
					intAck_d = 1'b1;
					resumePend_d = 1'b1;
					mode_d = RUN;
					evSet[EV_IDLE_WAKE] = 1'b1;
				end
			end
			PDOWN:
			begin
				// edge-mode inputs are ignored; an enabled level input low starts the clock
				if (extCfg_q[0] && extCfg_q[1] && !extSync)
				begin
					mode_d = WAKE;
					lowCnt_d = WAKE_CNT_W'(1);
				end
			end
			WAKE:
			begin
				// pin must stay low the full count; an early release drops back
				if (!extSync)
				begin
					if (lowCnt_q != WAKE_CNT_W'(WAKE_LOW_CYCLES))
					begin
						lowCnt_d = lowCnt_q + WAKE_CNT_W'(1);
					end
				end
				else if (lowCnt_q == WAKE_CNT_W'(WAKE_LOW_CYCLES))
				begin
					pwrReq_d[PDOWN_BIT] = 1'b0;
					pwrReq_d[IDLE_BIT] = 1'b0;
					intAck_d = 1'b1;
					resumePend_d = 1'b1;
					mode_d = RUN;
					evSet[EV_PDOWN_WAKE] = 1'b1;
				end
				else
				begin
					mode_d = PDOWN;
				end
			end
			default:
			begin
				mode_d = RUN;
			end
		endcase
	end

	// register file next values; set beats write-one clear
	always_comb
	begin
		extCfg_d = extCfg_q;
		evMask_d = evMask_q;
		evStat_d = evStat_q;
		if (wr && paddr == IRQ_STAT_OFS)
		begin
			evStat_d = evStat_q & ~pwdata[2:0];
		end
		else if (wr && paddr == IRQ_MASK_OFS)
		begin
			evMask_d = pwdata[2:0];
		end
		else if (wr && paddr == EXTCFG_OFS)
		begin
			extCfg_d = pwdata[1:0];
		end
		evStat_d = evStat_d | evSet;
		irq_d = |(evStat_d & evMask_d);
		prdata_d = 32'h0;
		pslverr_d = 1'b0;
		// error and data are registered from setup, the same edge as pready
		if (psel && !penable)
		begin
			if (paddr == CTRL_OFS)
			begin
				prdata_d = {30'h0, pwrReq_q};
			end
			else if (paddr == STAT_OFS)
			begin
				prdata_d = {18'h0, lowCnt_q, extSync, mode_q};
			end
			else if (paddr == IRQ_STAT_OFS)
			begin
				prdata_d = {29'h0, evStat_q};
			end
			else if (paddr == IRQ_MASK_OFS)
			begin
				prdata_d = {29'h0, evMask_q};
			end
			else if (paddr == EXTCFG_OFS)
			begin
				prdata_d = {30'h0, extCfg_q};
			end
			else
			begin
				pslverr_d = 1'b1;
			end
		end
		if (!rd)
		begin
			prdata_d = 32'h0;
		end
		pready_d = psel && !penable;
	end

	// core-facing outputs decoded from the next mode so they line up with it
	always_comb
	begin
		clkRun_d = (mode_d != PDOWN);
		pcHalt_d = (mode_d != RUN);
		ale_d = (mode_d == IDLE) || (mode_d == RUN);
		pss_d = (mode_d == IDLE) || (mode_d == RUN);
		if (mode_d == PDOWN || mode_d == WAKE)
		begin
			ale_d = 1'b0;
			pss_d = 1'b0;
		end
		if (mode_d == IDLE)
		begin
			ale_d = 1'b1;
			pss_d = 1'b1;
		end
	end

	// reset behaves as power-on: everything to defaults, from any mode
	// no other state is touched while asleep, so ram and sfr contents keep
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mode_q <= RUN;
			pwrReq_q <= CTRL_RESET[1:0];
			extCfg_q <= EXTCFG_RESET;
			evStat_q <= STAT_RESET;
			evMask_q <= MASK_RESET;
			lowCnt_q <= '0;
			resumePend_q <= 1'b0;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			intAck <= 1'b0;
			resumeNext <= 1'b0;
			irq <= 1'b0;
			clkRun <= 1'b1;
			pcHalt <= 1'b0;
			addrLatchStrobe <= 1'b1;
			program_store_strobe_n <= 1'b1;
		end
		else
		begin
			mode_q <= mode_d;
			pwrReq_q <= pwrReq_d;
			extCfg_q <= extCfg_d;
			evStat_q <= evStat_d;
			evMask_q <= evMask_d;
			lowCnt_q <= lowCnt_d;
			resumePend_q <= resumePend_d;
			prdata <= prdata_d;
			pready <= pready_d;
			pslverr <= pslverr_d;
			intAck <= intAck_d;
			resumeNext <= resumeNext_d;
			irq <= irq_d;
			clkRun <= clkRun_d;
			pcHalt <= pcHalt_d;
			addrLatchStrobe <= ale_d;
			program_store_strobe_n <= pss_d;
		end
	end

	// wake in power-down takes a full low period then a release
	sequence lowHeld_s;
		mode_q == WAKE && lowCnt_q == WAKE_CNT_W'(WAKE_LOW_CYCLES);
	endsequence
	sequence released_s;
		extSync;
	endsequence

	idleExit_a: assert property (@(posedge clk) disable iff (rst)
		mode_q == IDLE && !intPending |=> mode_q == IDLE)
		else $error("idle left without interrupt");
	idleClear_a: assert property (@(posedge clk) disable iff (rst)
		mode_q == IDLE && intPending |=> !pwrReq_q[IDLE_BIT] && intAck)
		else $error("idle bit not cleared on wake");
	resumeStep_a: assert property (@(posedge clk) disable iff (rst)
		mode_q == RUN && resumePend_q && retDone |=> resumeNext)
		else $error("resume pulse missing");
	pdClock_a: assert property (@(posedge clk) disable iff (rst)
		mode_q == PDOWN |-> !clkRun)
		else $error("clock running in power-down");
	edgeIgnored_a: assert property (@(posedge clk) disable iff (rst)
		mode_q == PDOWN && !extCfg_q[1] |=> mode_q == PDOWN)
		else $error("edge mode woke device");
	pdWake_a: assert property (@(posedge clk) disable iff (rst)
		lowHeld_s ##0 released_s |=> mode_q == RUN && !pwrReq_q[PDOWN_BIT])
		else $error("power-down exit failed");
	earlyRelease_a: assert property (@(posedge clk) disable iff (rst)
		mode_q == WAKE && extSync && lowCnt_q != WAKE_CNT_W'(WAKE_LOW_CYCLES)
		|=> mode_q == PDOWN)
		else $error("short low pulse woke device");
	isrFirst_a: assert property (@(posedge clk) disable iff (rst)
		lowHeld_s ##0 released_s |=> intAck ##1 !intAck)
		else $error("handler start not signalled");
	idleStrobes_a: assert property (@(posedge clk) disable iff (rst)
		mode_q == IDLE |-> addrLatchStrobe && program_store_strobe_n && pcHalt)
		else $error("idle strobes not high");
	pdStrobes_a: assert property (@(posedge clk) disable iff (rst)
		mode_q == PDOWN |-> !addrLatchStrobe && !program_store_strobe_n)
		else $error("power-down strobes not low");
	bothBits_a: assert property (@(posedge clk) disable iff (rst)
		mode_q == RUN && wr && paddr == CTRL_OFS && pwdata[1:0] == 2'h3 |=> mode_q == PDOWN)
		else $error("both bits did not pick power-down");

	// entry, retention and restart checks
	resetRun_a: assert property (@(posedge clk)
		rst |=> mode_q == RUN && pwrReq_q == 2'h0 && clkRun && !pcHalt)
		else $error("reset did not restart in run");
	idleClock_a: assert property (@(posedge clk) disable iff (rst)
		mode_q == IDLE |-> clkRun && pcHalt)
		else $error("idle clock or halt wrong");
	pdRetain_a: assert property (@(posedge clk) disable iff (rst)
		mode_q == PDOWN && !wr |=> $stable(evMask_q) && $stable(extCfg_q))
		else $error("register changed in power-down");
	idleEnter_a: assert property (@(posedge clk) disable iff (rst)
		mode_q == RUN && wr && paddr == CTRL_OFS && pwdata[1:0] == 2'h1 |=> mode_q == IDLE)
		else $error("idle request not taken");
	pdEnter_a: assert property (@(posedge clk) disable iff (rst)
		mode_q == RUN && wr && paddr == CTRL_OFS && pwdata[1:0] == 2'h2 |=> mode_q == PDOWN)
		else $error("power-down request not taken");
	// a low level in level mode must restart the clock at once
	lowWake_a: assert property (@(posedge clk) disable iff (rst)
		mode_q == PDOWN && extCfg_q == 2'h3 && !extSync |=> mode_q == WAKE && clkRun)
		else $error("low level did not restart clock");
	isrRun_a: assert property (@(posedge clk) disable iff (rst)
		lowHeld_s ##0 released_s |=> mode_q == RUN && !pcHalt)
		else $error("handler did not start after release");
	wakeStrobes_a: assert property (@(posedge clk) disable iff (rst)
		mode_q == WAKE |-> !addrLatchStrobe && !program_store_strobe_n && clkRun)
		else $error("wake strobes not low");
endmodule

// >>> verilog/sync2.sv
`timescale 1ns/1ps
// two-stage synchroniser; the first stage is read only by the second
module sync2 (
	input wire logic clk,
	input wire logic rst,
	input wire logic d,
	output logic q
);
	logic s1_q;
	logic s1_d;
	logic q_d;

	always_comb
	begin
		s1_d = d;
		q_d = s1_q;
	end

	// pin idles high, so reset to one keeps the wake detector quiet
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s1_q <= 1'b1;
			q <= 1'b1;
		end
		else
		begin
			s1_q <= s1_d;
			q <= q_d;
		end
	end
endmodule
